// ==== iaf_pkg.sv ====
// Purpose: shared constants, types and address decode for the indirect access and flags unit
// Assumes: single 20 MHz core clock, AXI4-Lite register access
// Notes: file-space addresses are 12 bits, data 8 bits
// Operation
// - three 12-bit file pointers, high and low byte, reach all 4096 bytes
// - indirect port access goes to the location held in its pointer, no storage
// - indirect read whose pointer names a port returns 00h and sets null
// - indirect write whose pointer names a port is a no-op, flags kept
// - five access addresses per pointer select how the pointer is modified
// - plain port keeps pointer; post ports use it then step by one
// - pre-increment port steps pointer first, then uses the new value
// - indexed port uses pointer plus signed accumulator, modifying neither
// - automatic pointer stepping never touches the condition flags
// - pointer stepping covers all 12 bits with carry into the high byte
// - a write to the pointer's own byte beats its step in that access
// - flag-affecting op aimed at the flag register: write dropped, logic sets flags
// - clearing the flag register clears upper bits, sets null, keeps the rest
// - flag register bits 7 to 5 read as zero
// - bit 4 copies the result's most significant bit
// - bit 3 set on signed overflow of the 7-bit magnitude
// - bit 2 set when the result is zero, else cleared
// - bit 1 is carry from bit 3 on add/sub; rotates through carry load bit 4 or 3
// - bit 0 is carry out of bit 7 on add/sub; rotates through carry load end bit
// - subtract adds two's complement, so carries mean no borrow
package iaf_pkg;
  // ==========================================================
  // sizes
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int NUM_PTR = 3;
  localparam int FLAGS_W = 5;
  // ==========================================================
  // axi register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_PTR0 = 8'h10;
  localparam logic [7:0] REG_PTR1 = 8'h14;
  localparam logic [7:0] REG_PTR2 = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int CMD_ADDR_LSB = 16;
  // ==========================================================
  // file-space map
  localparam logic [11:0] FILE_FLAGS = 12'hfd0;
  localparam logic [11:0] FILE_ACC = 12'hfd1;
  localparam logic [11:0] PTR_BLK_BASE = 12'hfe8;
  localparam logic [11:0] PTR_BLK_STEP = 12'h008;
  localparam logic [2:0] OFS_LO = 3'h0;
  localparam logic [2:0] OFS_HI = 3'h1;
  localparam logic [2:0] OFS_INDEXED = 3'h2;
  localparam logic [2:0] OFS_PREINC = 3'h3;
  localparam logic [2:0] OFS_POSTINC = 3'h4;
  localparam logic [2:0] OFS_POSTDEC = 3'h5;
  localparam logic [2:0] OFS_PLAIN = 3'h6;
  // ==========================================================
  // flag bits and masks
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [4:0] MASK_NONE = 5'h00;
  localparam logic [4:0] MASK_Z = 5'h04;
  localparam logic [4:0] MASK_ZN = 5'h14;
  localparam logic [4:0] MASK_ROT = 5'h17;
  localparam logic [4:0] MASK_ALL = 5'h1f;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    OP_MOVF, OP_MOVWF, OP_CLEAR_FILE_INSTRUCTION, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
    OP_COMF, OP_INCF, OP_DECF, OP_RLC, OP_RRC, OP_RLN, OP_RRN
  } iaf_op_t;
  typedef enum logic [2:0] {CLS_MEM, CLS_PORT, CLS_PTRLO, CLS_PTRHI, CLS_FLAGS, CLS_ACC} iaf_cls_t;
  typedef enum logic [2:0] {MD_PLAIN, MD_POSTDEC, MD_POSTINC, MD_PREINC, MD_INDEXED} iaf_mode_t;
  typedef struct packed {
    iaf_cls_t cls;
    logic [1:0] idx;
    iaf_mode_t mode;
  } iaf_dec_t;
  // ==========================================================
  // classify a file address
  function automatic iaf_dec_t iaf_decode(logic [11:0] a);
    iaf_dec_t d;
    logic [11:0] base;
    d = '{cls: CLS_MEM, idx: 2'h0, mode: MD_PLAIN};
    base = PTR_BLK_BASE;
    if (a == FILE_FLAGS) d.cls = CLS_FLAGS;
    if (a == FILE_ACC) d.cls = CLS_ACC;
    for (int n = 0; n < NUM_PTR; n++) begin
      if (a[11:3] == base[11:3]) begin
        d.idx = 2'(n);
        d.cls = CLS_PORT;
        case (a[2:0])
          OFS_LO: d.cls = CLS_PTRLO;
          OFS_HI: d.cls = CLS_PTRHI;
          OFS_INDEXED: d.mode = MD_INDEXED;
          OFS_PREINC: d.mode = MD_PREINC;
          OFS_POSTINC: d.mode = MD_POSTINC;
          OFS_POSTDEC: d.mode = MD_POSTDEC;
          OFS_PLAIN: d.mode = MD_PLAIN;
          default: d.cls = CLS_MEM;
        endcase
      end
      base = base - PTR_BLK_STEP;
    end
    return d;
  endfunction
endpackage

// ==== iaf_dmem_if.sv ====
// Purpose: carrier between the core and its data memory
// Assumes: read data registered, one cycle after the request
// Notes: none
interface iaf_dmem_if;
  logic en;
  logic we;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// ==== iaf_dmem.sv ====
// Purpose: 4096-byte data memory behind the indirect ports
// Assumes: synchronous write, registered read
// Notes: array has no reset, only the read register does
module iaf_dmem
  import iaf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  iaf_dmem_if.mem mif
);
  logic [7:0] ram [MEM_DEPTH];
  logic [7:0] rd_q;
  // ==========================================================
  // storage
  always_ff @(posedge clk_in) begin
    if (mif.en && mif.we) begin
      ram[mif.addr] <= mif.wdata;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= 8'h00;
    end else if (mif.en && !mif.we) begin
      rd_q <= ram[mif.addr];
    end
  end
  assign mif.rdata = rd_q;
endmodule

// ==== iaf_core.sv ====
// Purpose: indirect addressing pointers, access ports and alu condition flags
// Assumes: software drives operations through the command register over AXI4-Lite
// Notes: one operation at a time; register writes are refused while one runs
module iaf_core
  import iaf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in
);
  import iaf_pkg::*;
  // ==========================================================
  // types and state
  typedef enum logic {ST_IDLE, ST_EXEC} iaf_fsm_t;
  typedef struct packed {
    logic [7:0] res;
    logic [4:0] val;
    logic [4:0] mask;
  } iaf_alu_t;
  typedef struct packed {
    iaf_fsm_t fsm;
    logic [NUM_PTR-1:0][11:0] ptr;
    logic [7:0] acc;
    logic [4:0] flags;
    logic [7:0] result;
    iaf_op_t op;
    logic dest;
    iaf_dec_t src;
    iaf_dec_t tgt;
    logic [11:0] eff;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iaf_state_t;
  localparam iaf_state_t ST_RESET = '{
    fsm: ST_IDLE, ptr: '0, acc: 8'h00, flags: FLAGS_RESET, result: 8'h00,
    op: OP_MOVF, dest: 1'b0, src: '{CLS_MEM, 2'h0, MD_PLAIN}, tgt: '{CLS_MEM, 2'h0, MD_PLAIN},
    eff: 12'h000, aw_held: 1'b0, awaddr: 8'h00, w_held: 1'b0, wdata: 32'h0000_0000,
    wstrb: 4'h0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
    arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY};
  iaf_state_t st;
  iaf_state_t next_st;
  iaf_dmem_if mif ();
  logic mem_en;
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] fval;
  logic wr_file;
  // ==========================================================
  // alu: result value, flag values and which flags the op owns
  function automatic iaf_alu_t iaf_alu(iaf_op_t op, logic [7:0] f, logic [7:0] w, logic cin);
    iaf_alu_t r;
    logic [7:0] b;
    logic ci;
    logic [8:0] s;
    logic [4:0] h;
    r = '{res: f, val: MASK_NONE, mask: MASK_NONE};
    case (op)
      OP_SUB: b = ~w;
      OP_DECF: b = 8'hff;
      OP_INCF: b = 8'h00;
      default: b = w;
    endcase
    ci = (op == OP_SUB) || (op == OP_INCF);
    s = {1'b0, f} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, f[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    case (op)
      OP_MOVF: r.mask = MASK_ZN;
      OP_MOVWF: r.res = w;
      OP_CLEAR_FILE_INSTRUCTION: begin
        r.res = 8'h00;
        r.mask = MASK_Z;
      end
      OP_ADD, OP_SUB, OP_INCF, OP_DECF: begin
        r.res = s[7:0];
        r.mask = MASK_ALL;
        r.val[FLG_C] = s[8];
        r.val[FLG_DC] = h[4];
        r.val[FLG_OV] = (f[7] == b[7]) && (s[7] != f[7]);
      end
      OP_AND: begin
        r.res = f & w;
        r.mask = MASK_ZN;
      end
      OP_IOR: begin
        r.res = f | w;
        r.mask = MASK_ZN;
      end
      OP_XOR: begin
        r.res = f ^ w;
        r.mask = MASK_ZN;
      end
      OP_COMF: begin
        r.res = ~f;
        r.mask = MASK_ZN;
      end
      OP_RLC: begin
        r.res = {f[6:0], cin};
        r.mask = MASK_ROT;
        r.val[FLG_C] = f[7];
        r.val[FLG_DC] = f[3];
      end
      OP_RRC: begin
        r.res = {cin, f[7:1]};
        r.mask = MASK_ROT;
        r.val[FLG_C] = f[0];
        r.val[FLG_DC] = f[4];
      end
      OP_RLN: begin
        r.res = {f[6:0], f[7]};
        r.mask = MASK_ZN;
      end
      OP_RRN: begin
        r.res = {f[0], f[7:1]};
        r.mask = MASK_ZN;
      end
      default: r.res = f;
    endcase
    r.val[FLG_Z] = (r.res == 8'h00);
    r.val[FLG_N] = r.res[7];
    return r;
  endfunction
  // ==========================================================
  // next state
  always_comb begin
    iaf_alu_t a;
    iaf_dec_t d;
    logic [11:0] p;
    logic [11:0] e;
    logic [31:0] m;
    a = '{res: 8'h00, val: MASK_NONE, mask: MASK_NONE};
    d = iaf_decode(st.wdata[CMD_ADDR_LSB +: ADDR_W]);
    p = st.ptr[d.idx];
    e = st.wdata[CMD_ADDR_LSB +: ADDR_W];
    m = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    next_st = st;
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = st.eff;
    mem_wdata = 8'h00;
    fval = 8'h00;
    wr_file = (st.op == OP_MOVWF) || (st.op == OP_CLEAR_FILE_INSTRUCTION) || st.dest;
    // axi write capture, address and data in either order
    if (awvalid_in && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = awaddr_in;
      next_st.awready = 1'b0;
    end
    if (wvalid_in && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = wdata_in;
      next_st.wstrb = wstrb_in;
      next_st.wready = 1'b0;
    end
    if (st.bvalid && bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      // refusing writes mid-operation keeps pointer and flag updates atomic
      if (st.fsm != ST_IDLE) begin
        next_st.bresp = RESP_SLVERR;
      end else begin
        case (st.awaddr)
          REG_CMD: begin
            // start: resolve the access address now so memory reads in parallel
            if (d.cls == CLS_PORT) begin
              case (d.mode)
                MD_PREINC: e = p + 12'h001;
                MD_INDEXED: e = p + {{4{st.acc[7]}}, st.acc};
                default: e = p;
              endcase
            end
            next_st.fsm = ST_EXEC;
            next_st.op = iaf_op_t'(st.wdata[CMD_OP_LSB +: 4]);
            next_st.dest = st.wdata[CMD_DEST_BIT];
            next_st.src = d;
            next_st.tgt = iaf_decode(e);
            next_st.eff = e;
            mem_en = 1'b1;
            mem_addr = e;
          end
          REG_ACC: next_st.acc = (st.acc & ~m[7:0]) | (st.wdata[7:0] & m[7:0]);
          REG_FLAGS: begin
            next_st.flags = (st.flags & ~m[4:0]) | (st.wdata[4:0] & m[4:0]);
          end
          REG_RESULT: next_st.bresp = RESP_OKAY;
          REG_PTR0, REG_PTR1, REG_PTR2: begin
            p = st.ptr[st.awaddr[3:2]];
            next_st.ptr[st.awaddr[3:2]] = (p & ~m[11:0]) | (st.wdata[11:0] & m[11:0]);
          end
          default: next_st.bresp = RESP_SLVERR;
        endcase
      end
    end
    // axi read
    if (st.rvalid && rready_in) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    if (arvalid_in && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (araddr_in)
        REG_CMD: next_st.rdata = 32'(st.fsm == ST_EXEC);
        REG_ACC: next_st.rdata = 32'(st.acc);
        REG_FLAGS: next_st.rdata = 32'(st.flags);
        REG_RESULT: next_st.rdata = 32'(st.result);
        REG_PTR0, REG_PTR1, REG_PTR2: next_st.rdata = 32'(st.ptr[araddr_in[3:2]]);
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    // execute: operand in from memory or a special register
    if (st.fsm == ST_EXEC) begin
      case (st.tgt.cls)
        CLS_MEM: fval = mif.rdata;
        CLS_PORT: fval = 8'h00;
        CLS_PTRLO: fval = st.ptr[st.tgt.idx][7:0];
        CLS_PTRHI: fval = {4'h0, st.ptr[st.tgt.idx][11:8]};
        CLS_FLAGS: fval = {3'h0, st.flags};
        CLS_ACC: fval = st.acc;
        default: fval = 8'h00;
      endcase
      a = iaf_alu(st.op, fval, st.acc, st.flags[FLG_C]);
      next_st.result = a.res;
      next_st.fsm = ST_IDLE;
      // pointer step, flags untouched by it, full 12-bit wrap
      if (st.src.cls == CLS_PORT) begin
        p = st.ptr[st.src.idx];
        case (st.src.mode)
          MD_POSTDEC: next_st.ptr[st.src.idx] = p - 12'h001;
          MD_POSTINC, MD_PREINC: next_st.ptr[st.src.idx] = p + 12'h001;
          default: next_st.ptr[st.src.idx] = p;
        endcase
      end
      if (st.tgt.cls == CLS_PORT && wr_file) begin
        next_st.flags = st.flags;
      end else begin
        next_st.flags = (st.flags & ~a.mask) | (a.val & a.mask);
        if (st.tgt.cls == CLS_PORT) begin
          next_st.flags[FLG_Z] = 1'b1;
        end
      end
      if (!wr_file) begin
        next_st.acc = a.res;
      end else begin
        // later assignment makes the written byte beat the pointer step
        case (st.tgt.cls)
          CLS_MEM: begin
            mem_en = 1'b1;
            mem_we = 1'b1;
            mem_addr = st.eff;
            mem_wdata = a.res;
          end
          CLS_PTRLO: next_st.ptr[st.tgt.idx][7:0] = a.res;
          CLS_PTRHI: next_st.ptr[st.tgt.idx][11:8] = a.res[3:0];
          CLS_FLAGS: begin
            if (a.mask == MASK_NONE) begin
              next_st.flags = a.res[4:0];
            end
            // else only the flag bits in the op's mask come from the result logic, CLEAR keeps N/OV/DC/C
          end
          CLS_ACC: next_st.acc = a.res;
          default: mem_en = 1'b0;
        endcase
      end
    end
  end
  // ==========================================================
  // registers and memory
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end
  assign mif.en = mem_en;
  assign mif.we = mem_we;
  assign mif.addr = mem_addr;
  assign mif.wdata = mem_wdata;
  iaf_dmem u_dmem (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .mif(mif)
  );
  assign awready_out = st.awready;
  assign wready_out = st.wready;
  assign bvalid_out = st.bvalid;
  assign bresp_out = st.bresp;
  assign arready_out = st.arready;
  assign rvalid_out = st.rvalid;
  assign rdata_out = st.rdata;
  assign rresp_out = st.rresp;
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic exec;
  logic own_wr;
  logic [11:0] src_ptr;
  assign exec = (st.fsm == ST_EXEC);
  assign src_ptr = st.ptr[st.src.idx];
  assign own_wr = wr_file && (st.tgt.cls == CLS_PTRLO || st.tgt.cls == CLS_PTRHI)
                  && (st.tgt.idx == st.src.idx);
  a_post_inc_step: assert property (
    exec && st.src.cls == CLS_PORT && st.src.mode == MD_POSTINC && !own_wr
    |=> src_ptr == $past(src_ptr) + 12'h001)
    else $error("post-increment did not step pointer");
  a_ptr_wrap_zero: assert property (
    exec && st.src.cls == CLS_PORT && st.src.mode == MD_POSTINC && !own_wr
    && src_ptr == 12'hfff |=> src_ptr == 12'h000)
    else $error("pointer did not wrap to zero");
  a_pre_inc_addr: assert property (
    exec && st.src.cls == CLS_PORT && st.src.mode == MD_PREINC |-> st.eff == src_ptr + 12'h001)
    else $error("pre-increment address wrong");
  a_indexed_addr: assert property (
    exec && st.src.cls == CLS_PORT && st.src.mode == MD_INDEXED && !own_wr
    |-> st.eff == src_ptr + {{4{st.acc[7]}}, st.acc} ##1 $stable(src_ptr))
    else $error("indexed address wrong or pointer moved");
  a_self_read_zero: assert property (
    exec && st.tgt.cls == CLS_PORT && st.op == OP_MOVF && !wr_file
    |=> st.acc == 8'h00 && st.flags[FLG_Z])
    else $error("self-referencing read not zero");
  a_self_write_nop: assert property (
    exec && st.tgt.cls == CLS_PORT && wr_file |=> $stable(st.flags))
    else $error("self-referencing write changed flags");
  a_flags_clear: assert property (
    exec && st.tgt.cls == CLS_FLAGS && st.op == OP_CLEAR_FILE_INSTRUCTION |=> st.flags == ($past(st.flags) | MASK_Z))
    else $error("clear of flag register wrong");
  a_flags_guard: assert property (
    exec && st.tgt.cls == CLS_FLAGS && st.op == OP_ADD && wr_file
    |=> st.flags[FLG_N] == st.result[7] && st.flags[FLG_Z] == (st.result == 8'h00))
    else $error("flag register write not discarded");
  a_sub_no_borrow: assert property (
    exec && st.op == OP_SUB && st.tgt.cls != CLS_PORT
    |=> st.flags[FLG_C] == ($past(fval) >= $past(st.acc)))
    else $error("subtract carry is not inverted borrow");
  a_move_no_flags: assert property (
    exec && st.op == OP_MOVWF && st.tgt.cls != CLS_FLAGS |=> $stable(st.flags))
    else $error("flags changed by a move");
  a_bvalid_hold: assert property (
    st.bvalid && !bready_in |=> st.bvalid)
    else $error("write response dropped early");
  c_post_inc: cover property (exec && st.src.mode == MD_POSTINC && st.src.cls == CLS_PORT);
  c_self_ref: cover property (exec && st.tgt.cls == CLS_PORT);
  c_flags_clear: cover property (exec && st.tgt.cls == CLS_FLAGS && st.op == OP_CLEAR_FILE_INSTRUCTION);
  c_own_write: cover property (exec && own_wr);
endmodule

// ==== iaf_axi_bus.sv ====
// Purpose: axi4-lite master that stands in for software on the register bus
// Assumes: one clock; the slave's outputs are registers
// Notes: one transfer at a time; only the bench timeout ends a wait
interface iaf_axi_bus (input wire logic clk_in);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  initial begin
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
  end
  // ==========================================================
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // ==========================================================
  // read: rready held from the start so the answer is taken when seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endinterface

// ==== iaf_core_tb.sv ====
// Purpose: self-checking bench for the pointer and flag unit
// Assumes: memory read only where written before
// Notes: model state is kept in plain variables beside the bus traffic
module iaf_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iaf_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'd71;
  logic [7:0] mem [int];
  logic [11:0] mp [3] = '{12'h0, 12'h0, 12'h0};
  logic [7:0] macc = 8'h0;
  logic [4:0] mfl = 5'h0;
  logic [7:0] mres = 8'h0;
  iaf_axi_bus bus (.clk_in(clk_in));
  iaf_core u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .awaddr_in(bus.awaddr), .awvalid_in(bus.awvalid), .awready_out(bus.awready),
    .wdata_in(bus.wdata), .wstrb_in(bus.wstrb), .wvalid_in(bus.wvalid),
    .wready_out(bus.wready), .bresp_out(bus.bresp), .bvalid_out(bus.bvalid),
    .bready_in(bus.bready), .araddr_in(bus.araddr), .arvalid_in(bus.arvalid),
    .arready_out(bus.arready), .rdata_out(bus.rdata), .rresp_out(bus.rresp),
    .rvalid_out(bus.rvalid), .rready_in(bus.rready));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // ==========================================================
  // checking and reporting
  task automatic print_verdict();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_d(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t data exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_r(input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t resp exp %h got %h", $time, e, g);
    end
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ==========================================================
  // reference model of the file space
  function automatic logic [7:0] fget(logic [11:0] t);
    if (t == FILE_FLAGS) return {3'h0, mfl};
    if (t == FILE_ACC) return macc;
    for (int n = 0; n < 3; n++) begin
      if (t == PTR_BLK_BASE - 12'(8 * n)) return mp[n][7:0];
      if (t == PTR_BLK_BASE + 12'h1 - 12'(8 * n)) return {4'h0, mp[n][11:8]};
    end
    return mem.exists(t) ? mem[t] : 8'h00;
  endfunction
  function automatic void fset(logic [11:0] t, logic [7:0] v);
    if (t == FILE_FLAGS) mfl = v[4:0];
    else if (t == FILE_ACC) macc = v;
    else mem[t] = v;
    for (int n = 0; n < 3; n++) begin
      if (t == PTR_BLK_BASE - 12'(8 * n)) mp[n][7:0] = v;
      if (t == PTR_BLK_BASE + 12'h1 - 12'(8 * n)) mp[n][11:8] = v[3:0];
    end
  endfunction
  task automatic m_exec(input iaf_op_t op, input logic dest, input logic [11:0] fa);
    int n, k, ci;
    logic [11:0] t, b;
    logic [8:0] s;
    logic [7:0] f, wx;
    logic [4:0] m, nf;
    bit wf, self, own;
    n = 0;
    k = -1;
    t = fa;
    if (fa >= 12'hfd8 && fa <= 12'hfef) begin
      n = 2 - int'((fa - 12'hfd8) >> 3);
      k = int'(fa[2:0]);
    end
    b = PTR_BLK_BASE - 12'(8 * n);
    if (k >= 2 && k <= 6) begin
      if (k == 3) mp[n] = mp[n] + 12'h1;
      t = (k == 2) ? mp[n] + {{4{macc[7]}}, macc} : mp[n];
    end
    self = t >= 12'hfd8 && t <= 12'hfef && t[2:0] >= 3'h2 && t[2:0] <= 3'h6;
    own = k >= 2 && k <= 6 && (t == b || t == b + 12'h1);
    wf = op == OP_MOVWF || op == OP_CLEAR_FILE_INSTRUCTION || dest;
    f = self ? 8'h00 : fget(t);
    wx = (op == OP_SUB) ? ~macc : macc;
    if (op == OP_INCF) wx = 8'h00;
    if (op == OP_DECF) wx = 8'hff;
    ci = (op == OP_SUB || op == OP_INCF);
    s = 9'(f + wx + ci);
    m = (op inside {OP_ADD, OP_SUB, OP_INCF, OP_DECF}) ? MASK_ALL : MASK_ZN;
    case (op)
      OP_MOVF: s = {1'b0, f};
      OP_MOVWF: s = {1'b0, macc};
      OP_CLEAR_FILE_INSTRUCTION: s = 9'h0;
      OP_AND: s = {1'b0, f & macc};
      OP_IOR: s = {1'b0, f | macc};
      OP_XOR: s = {1'b0, f ^ macc};
      OP_COMF: s = {1'b0, ~f};
      OP_RLC: s = {f, mfl[0]};
      OP_RRC: s = {f[0], mfl[0], f[7:1]};
      OP_RLN: s = {1'b0, f[6:0], f[7]};
      OP_RRN: s = {1'b0, f[0], f[7:1]};
      default: ;
    endcase
    if (op == OP_MOVWF) m = MASK_NONE;
    if (op == OP_CLEAR_FILE_INSTRUCTION) m = MASK_Z;
    if (op == OP_RLC || op == OP_RRC) m = MASK_ROT;
    mres = s[7:0];
    if (wf && self) return;
    nf[4] = s[7];
    nf[3] = (f[7] == wx[7]) && (s[7] != f[7]);
    nf[2] = s[7:0] == 8'h0;
    nf[1] = ({1'b0, f[3:0]} + wx[3:0] + ci) > 15;
    if (op == OP_RLC) nf[1] = f[3];
    if (op == OP_RRC) nf[1] = f[4];
    nf[0] = s[8];
    if (!wf) macc = s[7:0];
    else if (!(t == FILE_FLAGS && m != MASK_NONE)) fset(t, s[7:0]);
    mfl = (mfl & ~m) | (nf & m);
    if (!(wf && own) && k == 4) mp[n] = mp[n] + 12'h1;
    if (!(wf && own) && k == 5) mp[n] = mp[n] - 12'h1;
  endtask
  // ==========================================================
  // register traffic
  task automatic get(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    bus.rd(a, d, r);
    chk_d(e, d);
    chk_r(RESP_OKAY, r);
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] r;
    bus.wr(a, v, r);
    chk_r(RESP_OKAY, r);
    if (a == REG_ACC) macc = v[7:0];
    if (a == REG_FLAGS) mfl = v[4:0];
    if (a >= REG_PTR0) mp[(a - REG_PTR0) / 4] = v[11:0];
  endtask
  task automatic cmd(input iaf_op_t op, input logic dest, input logic [11:0] fa);
    logic [1:0] r;
    bus.wr(REG_CMD, {4'h0, fa, 11'h0, dest, op}, r);
    chk_r(RESP_OKAY, r);
    m_exec(op, dest, fa);
    get(REG_ACC, {24'h0, macc});
    get(REG_FLAGS, {27'h0, mfl});
    get(REG_RESULT, {24'h0, mres});
    for (int n = 0; n < 3; n++) get(REG_PTR0 + 8'(4 * n), {20'h0, mp[n]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    get(REG_FLAGS, 32'h0);
    get(REG_PTR0, 32'h0);
    get(REG_CMD, 32'h0);
    bus.rd(8'h1c, d, r);
    chk_d(32'h0, d);
    chk_r(RESP_SLVERR, r);
    bus.wr(8'h20, rnd(), r);
    chk_r(RESP_SLVERR, r);
    put(REG_FLAGS, 32'hff);
    get(REG_FLAGS, 32'h1f);
    put(REG_PTR0, 32'hfffff0ff);
    get(REG_PTR0, 32'h0ff);
    for (int i = 0; i < 4; i++) begin
      put(REG_ACC, rnd() & 32'hff);
      cmd(OP_MOVWF, 1'b1, 12'hfec);
    end
    put(REG_PTR1, 32'h100);
    put(REG_ACC, 32'h2);
    cmd(OP_MOVF, 1'b0, 12'hfe2);
    put(REG_ACC, 32'hff);
    cmd(OP_MOVF, 1'b0, 12'hfe2);
    cmd(OP_MOVF, 1'b0, 12'hfe3);
    cmd(OP_MOVF, 1'b0, 12'hfe5);
    for (int i = 0; i < 15; i++) begin
      put(REG_ACC, rnd() & 32'hff);
      cmd(iaf_op_t'(4'(3 + i % 12)), 1'(i / 10), 12'hfe6);
    end
    cmd(OP_ADD, 1'b1, FILE_FLAGS);
    put(REG_FLAGS, 32'h0b);
    cmd(OP_CLEAR_FILE_INSTRUCTION, 1'b1, FILE_FLAGS);
    put(REG_PTR2, 32'hfee);
    cmd(OP_MOVF, 1'b0, 12'hfde);
    put(REG_FLAGS, 32'h0);
    cmd(OP_CLEAR_FILE_INSTRUCTION, 1'b1, 12'hfde);
    put(REG_PTR0, 32'hfe8);
    put(REG_ACC, 32'h5a);
    cmd(OP_MOVWF, 1'b1, 12'hfec);
    put(REG_ACC, 32'h81);
    cmd(OP_MOVWF, 1'b1, 12'hfff);
    put(REG_PTR0, 32'hfff);
    cmd(OP_MOVF, 1'b0, 12'hfec);
    print_verdict();
  end
endmodule
